// File: hw/scr_defs.svh
// Purpose: Named constants for the sensor configuration and burst register bank
// Assumes: Seven-bit register addresses, eight-bit register data
// Notes:   Definitions only
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// Register addresses
`define SCR_ADDR_REVISION   7'h01
`define SCR_ADDR_RES_SEL    7'h19
`define SCR_ADDR_LED_FORCE  7'h22
`define SCR_ADDR_SOFT_RST   7'h3a
`define SCR_ADDR_PART_ID    7'h3e
`define SCR_ADDR_INV_REV    7'h3f
`define SCR_ADDR_BURST      7'h63

// Command values and fields
`define SCR_LED_ON_VAL      8'h80
`define SCR_SOFT_RST_VAL    8'h5a
`define SCR_RES_UPDATE_BIT  4
`define SCR_WRITE_BIT       7
`define SCR_RESERVED_READ   8'h00
`define SCR_LED_RESET       8'h00
`define SCR_RES_SEL_RESET   8'h08

// Resolution codes
`define SCR_CPI_STEP        11'h07d
`define SCR_CPI_CODE_MIN    4'h1
`define SCR_CPI_CODE_MAX    4'hb
`define SCR_CPI_CODE_RESET  4'h4

// Burst sequence
`define SCR_BURST_FIRST     3'h0
`define SCR_BURST_LAST      3'h6
`define SCR_BIT_LAST        3'h7

`endif

// File: hw/scr_pkg.sv
// Purpose: Types for the sensor configuration and burst register bank
// Assumes: Nothing beyond the defines header
// Notes:   One-hot serial port states
package scr_pkg;

  // Serial port phase
  typedef enum logic [2:0] {
    ST_ADDR = 3'b001,  // Shifting in the address byte
    ST_WR   = 3'b010,  // Shifting in write data
    ST_RD   = 3'b100   // Shifting out read data
  } scr_state_type;

endpackage : scr_pkg

// File: hw/scr_top.sv
// Purpose: Three-wire serial register bank with resolution, LED, reset, identity and motion burst
// Assumes: Serial clock, data and select come from the host and are synchronised to clk_in
// Notes:   Address byte MSB high means write; data moves MSB first, sampled on rising serial clock
`include "scr_defs.svh"

module scr_top
  import scr_pkg::*;
#(
  parameter logic [7:0] PART_ID  = 8'h5c,  // Arbitrary identity value
  parameter logic [7:0] REVISION = 8'h03   // Arbitrary revision value
) (
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  // Serial pins
  input  wire logic        sclk_in,
  input  wire logic        select_low_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  // Motion data from the imaging core
  input  wire logic [7:0]  motion_x_in,
  input  wire logic [7:0]  motion_y_in,
  input  wire logic [7:0]  surface_quality_in,
  input  wire logic [15:0] exposure_in,
  input  wire logic [7:0]  brightest_pixel_in,
  input  wire logic [7:0]  pixel_total_in,
  // Illumination and configuration
  input  wire logic        led_pulse_in,
  output logic             led_drive_out,
  output logic [3:0]       counts_per_inch_code_out,
  output logic [10:0]      counts_per_inch_out,
  output logic             soft_reset_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [2:0]    sclk_sync_q;   // Two sync stages plus edge history
  logic [2:0]    sel_sync_q;    // Select sync plus history
  logic [1:0]    sdio_sync_q;   // Data sync
  logic          soft_rst_q;    // Internal reset pulse
  logic          int_rst;       // Pin or command reset

  assign int_rst = sys_rst_in | soft_rst_q;

  // Two flops per pin, plus a history flop for serial clock and select only
  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      sclk_sync_q <= 3'h0;
      sel_sync_q  <= 3'h7;
      sdio_sync_q <= 2'h0;
    end else if (ce_in) begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
      sel_sync_q  <= {sel_sync_q[1:0], select_low_n_in};
      sdio_sync_q <= {sdio_sync_q[0], sdio_in};
    end
  end

  wire sclk_rise = ce_in & sclk_sync_q[1] & ~sclk_sync_q[2];   // Serial clock rising
  wire sclk_fall = ce_in & ~sclk_sync_q[1] & sclk_sync_q[2];   // Serial clock falling
  wire selected  = ~sel_sync_q[1];                             // Chip selected
  wire sel_rise  = ce_in & sel_sync_q[1] & ~sel_sync_q[2];     // Select released
  wire sdio_bit  = sdio_sync_q[1];                             // Sampled data bit

  //////////////////////////////////////////////////////////////////////////////
  // Serial framing state

  scr_state_type st_q;          // Port phase
  logic [2:0]    bit_cnt_q;     // Bit within byte
  logic [6:0]    shift_q;       // Incoming bits
  logic [6:0]    addr_q;        // Current address
  logic          burst_q;       // Burst mode active
  logic [7:0]    tx_q;          // Outgoing byte

  wire       byte_done = sclk_rise & selected & (bit_cnt_q == `SCR_BIT_LAST);
  wire [7:0] rx_byte   = {shift_q, sdio_bit};
  wire       wr_stb    = byte_done & (st_q == ST_WR);          // Write data complete
  wire       rd_start  = byte_done & (st_q == ST_ADDR) & ~rx_byte[`SCR_WRITE_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry read data buffer

  logic [7:0] buf_mem [2];      // Buffer storage
  logic       buf_wr_q;         // Write pointer
  logic       buf_rd_q;         // Read pointer
  logic [1:0] buf_cnt_q;        // Occupancy
  logic       buf_push;         // Filling side valid
  logic [7:0] buf_push_data;    // Filling side data
  wire        buf_ready = (buf_cnt_q != 2'h2);                  // Filling side ready
  wire        buf_valid = (buf_cnt_q != 2'h0);                  // Draining side valid
  wire        buf_pop   = sclk_fall & selected & (st_q == ST_RD) & (bit_cnt_q == 3'h0) & buf_valid;
  wire        buf_flush = sel_rise | rd_start;
  wire [7:0]  buf_head  = buf_mem[buf_rd_q];

  // Pointers and count, flushed at each new read and at deselect
  always_ff @(posedge clk_in) begin
    if (int_rst || (ce_in && buf_flush)) begin
      buf_wr_q  <= 1'b0;
      buf_rd_q  <= 1'b0;
      buf_cnt_q <= 2'h0;
    end else if (ce_in) begin
      if (buf_push && buf_ready) buf_wr_q <= ~buf_wr_q;
      if (buf_pop) buf_rd_q <= ~buf_rd_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push & buf_ready} - {1'b0, buf_pop};
    end
  end

  // Storage writes
  always_ff @(posedge clk_in) begin
    if (ce_in && buf_push && buf_ready) buf_mem[buf_wr_q] <= buf_push_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  led_q;           // LED mode register
  logic [3:0]  cpi_code_q;      // Applied resolution code
  logic [10:0] cpi_q;           // Applied resolution in cpi
  logic        fetched_q;       // Single read byte already loaded
  logic [2:0]  burst_idx_q;     // Burst address counter

  wire wr_res = wr_stb & (addr_q == `SCR_ADDR_RES_SEL);
  wire wr_led = wr_stb & (addr_q == `SCR_ADDR_LED_FORCE);
  wire wr_rst = wr_stb & (addr_q == `SCR_ADDR_SOFT_RST) & (rx_byte == `SCR_SOFT_RST_VAL);
  wire code_ok = (rx_byte[3:0] >= `SCR_CPI_CODE_MIN) & (rx_byte[3:0] <= `SCR_CPI_CODE_MAX);
  wire res_apply = wr_res & rx_byte[`SCR_RES_UPDATE_BIT] & code_ok;

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] led);
    case (a)
      `SCR_ADDR_REVISION:  reg_read = REVISION;
      `SCR_ADDR_LED_FORCE: reg_read = led;
      `SCR_ADDR_PART_ID:   reg_read = PART_ID;
      `SCR_ADDR_INV_REV:   reg_read = ~REVISION;
      default:             reg_read = `SCR_RESERVED_READ;
    endcase
  endfunction : reg_read

  // Burst byte order
  logic [7:0] burst_byte;
  always_comb begin
    case (burst_idx_q)
      3'h0:    burst_byte = motion_x_in;
      3'h1:    burst_byte = motion_y_in;
      3'h2:    burst_byte = surface_quality_in;
      3'h3:    burst_byte = exposure_in[15:8];
      3'h4:    burst_byte = exposure_in[7:0];
      3'h5:    burst_byte = brightest_pixel_in;
      default: burst_byte = pixel_total_in;
    endcase
  end

  assign buf_push      = (st_q == ST_RD) & (burst_q | ~fetched_q);
  assign buf_push_data = burst_q ? burst_byte : reg_read(addr_q, led_q);

  // Writable registers; other addresses change nothing, except the soft reset command, which reloads them
  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      led_q      <= `SCR_LED_RESET;
      cpi_code_q <= `SCR_CPI_CODE_RESET;
      cpi_q      <= 11'(`SCR_CPI_CODE_RESET * `SCR_CPI_STEP);
    end else if (ce_in) begin
      if (wr_led) led_q <= rx_byte;
      if (res_apply) cpi_code_q <= rx_byte[3:0];
      cpi_q <= 11'(cpi_code_q * `SCR_CPI_STEP);
    end
  end

  // Command reset pulse, cleared by its own next cycle or by the pin reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) soft_rst_q <= 1'b0;
    else if (ce_in) soft_rst_q <= wr_rst;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial port sequencer

  always_ff @(posedge clk_in) begin
    if (int_rst || (ce_in && sel_rise)) begin
      st_q        <= ST_ADDR;
      bit_cnt_q   <= 3'h0;
      shift_q     <= 7'h00;
      addr_q      <= 7'h00;
      burst_q     <= 1'b0;
      fetched_q   <= 1'b0;
      burst_idx_q <= `SCR_BURST_FIRST;
      tx_q        <= 8'h00;
    end else if (ce_in) begin
      // Loader bookkeeping
      if (buf_push && buf_ready) begin
        fetched_q <= 1'b1;
        if (burst_q && burst_idx_q != `SCR_BURST_LAST) burst_idx_q <= burst_idx_q + 3'h1;
      end
      // Shift out on falling edges
      if (sclk_fall && selected && st_q == ST_RD) begin
        if (bit_cnt_q == 3'h0) tx_q <= buf_valid ? buf_head : `SCR_RESERVED_READ;
        else tx_q <= {tx_q[6:0], 1'b0};
      end
      // Count and sample on rising edges
      if (sclk_rise && selected) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q   <= {shift_q[5:0], sdio_bit};
        if (bit_cnt_q == `SCR_BIT_LAST) begin
          case (st_q)
            ST_ADDR: begin
              addr_q      <= rx_byte[6:0];
              st_q        <= rx_byte[`SCR_WRITE_BIT] ? ST_WR : ST_RD;
              burst_q     <= ~rx_byte[`SCR_WRITE_BIT] & (rx_byte[6:0] == `SCR_ADDR_BURST);
              fetched_q   <= 1'b0;
              burst_idx_q <= `SCR_BURST_FIRST;
            end
            ST_WR: begin
              st_q <= ST_ADDR;
            end
            ST_RD: begin
              st_q <= burst_q ? ST_RD : ST_ADDR;
            end
            default: begin
              st_q <= ST_ADDR;
            end
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sdio_out                 = tx_q[7];
  assign sdio_oe_out              = (st_q == ST_RD) & selected;
  assign led_drive_out            = (led_q == `SCR_LED_ON_VAL) | led_pulse_in;
  assign counts_per_inch_code_out = cpi_code_q;
  assign counts_per_inch_out      = cpi_q;
  assign soft_reset_out           = soft_rst_q;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_res_gate;
    @(posedge clk_in) disable iff (int_rst)
    (ce_in && wr_res && !rx_byte[`SCR_RES_UPDATE_BIT]) |=> $stable(cpi_code_q);
  endproperty
  a_res_gate: assert property (p_res_gate) else $error("resolution changed without enable");

  property p_cpi;
    @(posedge clk_in) disable iff (int_rst)
    (ce_in && res_apply) |-> ##2 (counts_per_inch_out == 11'($past(rx_byte[3:0], 2) * `SCR_CPI_STEP));
  endproperty
  a_cpi: assert property (p_cpi) else $error("cpi value wrong after apply");

  property p_led;
    @(posedge clk_in) disable iff (int_rst)
    (ce_in && wr_led && rx_byte == `SCR_LED_ON_VAL) |=> led_drive_out;
  endproperty
  a_led: assert property (p_led) else $error("led not held on");

  property p_rst;
    @(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && wr_rst) |=> soft_reset_out ##1 (led_q == `SCR_LED_RESET);
  endproperty
  a_rst: assert property (p_rst) else $error("command reset missing");

  property p_id;
    @(posedge clk_in) disable iff (int_rst)
    (buf_push && !burst_q && addr_q == `SCR_ADDR_PART_ID) |-> (buf_push_data == PART_ID);
  endproperty
  a_id: assert property (p_id) else $error("identity value wrong");

  property p_inv;
    @(posedge clk_in) disable iff (int_rst)
    (buf_push && !burst_q && addr_q == `SCR_ADDR_INV_REV) |-> (buf_push_data == ~REVISION);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted revision wrong");

  sequence s_burst_start;
    ce_in && rd_start && rx_byte[6:0] == `SCR_ADDR_BURST && !sel_rise;
  endsequence
  property p_burst_first;
    @(posedge clk_in) disable iff (int_rst)
    s_burst_start |=> (burst_q && burst_idx_q == `SCR_BURST_FIRST && buf_push_data == motion_x_in);
  endproperty
  a_burst_first: assert property (p_burst_first) else $error("burst does not start with x motion");

  property p_burst_hold;
    @(posedge clk_in) disable iff (int_rst)
    (ce_in && burst_q && burst_idx_q == `SCR_BURST_LAST && !sel_rise) |=> (burst_idx_q == `SCR_BURST_LAST);
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst counter moved past last byte");

  property p_desel;
    @(posedge clk_in) disable iff (int_rst)
    (ce_in && sel_rise) |=> (st_q == ST_ADDR && !burst_q && buf_cnt_q == 2'h0);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect did not end transfer");

  property p_reserved_wr;
    @(posedge clk_in) disable iff (int_rst)
    (ce_in && wr_stb && addr_q != `SCR_ADDR_LED_FORCE) |=> $stable(led_q);
  endproperty
  a_reserved_wr: assert property (p_reserved_wr) else $error("other write changed led register");

endmodule : scr_top

// File: sim/scr_host_model.sv
// Purpose: Serial host model for the sensor register bank
// Assumes: Serial period 200 ns, eight system clocks
// Notes:   Clock idles high; a released data line toggles every clock
module scr_host_model (
  // System clock
  input  wire logic clk_in,
  // Serial pins
  input  wire logic sdio_line_in,
  output logic      sclk_out,
  output logic      select_low_n_out,
  output logic      sdio_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       drive_q = 1'b1;  // Host owns the data line
  logic [7:0] rx_byte;         // Last byte read
  event       got_ev;          // A read byte is ready

  initial begin
    sclk_out = 1'b1;
    select_low_n_out = 1'b1;
    sdio_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Released line shows no stale value
  always @(posedge clk_in) begin
    if (!drive_q) begin
      sdio_out <= ~sdio_out;
    end
  end

  // One bit: fall and set data, rise after four clocks and sample
  task automatic shift_bit(input logic b, input logic drv, output logic r);
    sclk_out <= 1'b0;
    drive_q  <= drv;
    if (drv) begin
      sdio_out <= b;
    end
    repeat (4) @(posedge clk_in);
    sclk_out <= 1'b1;
    #1;
    r = sdio_line_in;
    repeat (4) @(posedge clk_in);
  endtask : shift_bit

  // Whole frame: header, optional write byte, nrd read bytes
  task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] wd, input int nrd);
    logic [7:0] hdr;
    logic [7:0] rb;
    hdr = {wr, addr};
    @(posedge clk_in);
    select_low_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(hdr[i], 1'b1, rb[i]);
    end
    for (int i = 7; i >= 0 && wr; i--) begin
      shift_bit(wd[i], 1'b1, rb[i]);
    end
    for (int n = 0; n < nrd; n++) begin
      for (int i = 7; i >= 0; i--) begin
        shift_bit(1'b0, 1'b0, rb[i]);
      end
      rx_byte = rb;
      ->got_ev;
    end
    select_low_n_out <= 1'b1;
    drive_q <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask : frame
endmodule : scr_host_model

// File: sim/scr_top_tb.sv
// Purpose: Self-checking bench for the sensor register bank
// Assumes: 40 MHz clock, host model on the serial pins
// Notes:   Read bytes are checked against a queue of expected values
`include "scr_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end

module scr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] PID = 8'h4b;  // Arbitrary identity value
  localparam logic [7:0] REV = 8'h21;  // Arbitrary revision value
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        led_pulse_in = 1'b0;
  logic [7:0]  mx = 8'h00, my = 8'h00, sq = 8'h00, bp = 8'h00, pt = 8'h00;
  logic [15:0] ex = 16'h0000;
  logic        sclk, sel_n, host_sdio, sdio_o, sdio_oe, led_drive, soft_rst;
  logic [3:0]  cpi_code;
  logic [10:0] cpi;
  wire         sdio_line = sdio_oe ? sdio_o : host_sdio;  // Shared data wire
  int          num_errors = 0, comparisons = 0, pulses = 0;
  integer      seed = 32'h636c;
  logic [7:0]  exp_q[$];
  logic [7:0]  want_b;                                    // Oldest note, popped once

  always #12.5 clk_in = ~clk_in;

  scr_top #(.PART_ID(PID), .REVISION(REV)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .sclk_in(sclk),
    .select_low_n_in(sel_n), .sdio_in(sdio_line), .sdio_out(sdio_o),
    .sdio_oe_out(sdio_oe), .motion_x_in(mx), .motion_y_in(my), .surface_quality_in(sq),
    .exposure_in(ex), .brightest_pixel_in(bp), .pixel_total_in(pt), .led_pulse_in(led_pulse_in),
    .led_drive_out(led_drive), .counts_per_inch_code_out(cpi_code), .counts_per_inch_out(cpi),
    .soft_reset_out(soft_rst));

  scr_host_model host_u (.clk_in(clk_in), .sdio_line_in(sdio_line), .sclk_out(sclk),
    .select_low_n_out(sel_n), .sdio_out(host_sdio));

  ////////////////////////////////////////////////////////////////
  // Oldest note against each byte the host reads
  always @(host_u.got_ev) begin
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp none", $time, host_u.rx_byte);
    end else begin
      want_b = exp_q.pop_front();
      `CHK(host_u.rx_byte, want_b)
    end
  end

  // Count soft reset pulses
  always @(posedge clk_in) begin
    if (soft_rst === 1'b1) begin
      pulses++;
    end
  end

  task automatic rd(input logic [6:0] a, input int n);
    host_u.frame(1'b0, a, 8'h00, n);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.frame(1'b1, a, d, 0);
  endtask : wr

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [3:0]  code, want;
    logic        en;
    logic [7:0]  v;
    logic [31:0] w;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHK(cpi_code, `SCR_CPI_CODE_RESET)
    `CHK(cpi, 11'h1f4)
    `CHK(led_drive, 1'b0)
    `CHK(sdio_oe, 1'b0)
    `CHK(soft_rst, 1'b0)
    exp_q.push_back(PID);
    exp_q.push_back(~REV);
    exp_q.push_back(REV);
    exp_q.push_back(`SCR_RESERVED_READ);
    exp_q.push_back(`SCR_LED_RESET);
    exp_q.push_back(PID);
    rd(`SCR_ADDR_PART_ID, 1);
    rd(`SCR_ADDR_INV_REV, 1);
    rd(`SCR_ADDR_REVISION, 1);
    rd(7'h40, 1);
    rd(`SCR_ADDR_LED_FORCE, 1);
    wr(`SCR_ADDR_PART_ID, 8'h00);
    wr(7'h45, 8'hff);
    rd(`SCR_ADDR_PART_ID, 1);
    $display("test identity done");
    want = `SCR_CPI_CODE_RESET;
    for (int i = 0; i < 20; i++) begin
      v = $random(seed);
      en = (i < 16) ? 1'b1 : i[0];
      // A refused write carries a code other than the applied one
      code = (i < 16) ? 4'(i) : (en ? v[3:0] : ~want);
      if (en && code >= `SCR_CPI_CODE_MIN && code <= `SCR_CPI_CODE_MAX) begin
        want = code;
      end
      wr(`SCR_ADDR_RES_SEL, {3'b000, en, code});
      `CHK(cpi_code, want)
      `CHK(cpi, 11'(want) * 11'h07d)
    end
    $display("test resolution done");
    wr(`SCR_ADDR_LED_FORCE, `SCR_LED_ON_VAL);
    `CHK(led_drive, 1'b1)
    exp_q.push_back(`SCR_LED_ON_VAL);
    rd(`SCR_ADDR_LED_FORCE, 1);
    wr(`SCR_ADDR_LED_FORCE, 8'h81);
    `CHK(led_drive, 1'b0)
    led_pulse_in <= 1'b1;
    @(posedge clk_in);
    #1;
    `CHK(led_drive, 1'b1)
    @(posedge clk_in);
    led_pulse_in <= 1'b0;
    $display("test led done");
    w = $random(seed);
    mx <= w[7:0];
    my <= w[15:8];
    sq <= w[23:16];
    bp <= w[31:24];
    w = $random(seed);
    pt <= w[7:0];
    ex <= w[23:8];
    @(posedge clk_in);
    exp_q.push_back(mx);
    exp_q.push_back(my);
    exp_q.push_back(sq);
    exp_q.push_back(ex[15:8]);
    exp_q.push_back(ex[7:0]);
    exp_q.push_back(bp);
    repeat (4) exp_q.push_back(pt);
    rd(`SCR_ADDR_BURST, 10);
    `CHK(sdio_oe, 1'b0)
    exp_q.push_back(PID);
    rd(`SCR_ADDR_PART_ID, 1);
    exp_q.push_back(mx);
    exp_q.push_back(my);
    rd(`SCR_ADDR_BURST, 2);
    $display("test burst done");
    wr(`SCR_ADDR_RES_SEL, 8'h17);
    wr(`SCR_ADDR_LED_FORCE, `SCR_LED_ON_VAL);
    pulses = 0;
    wr(`SCR_ADDR_SOFT_RST, 8'h5b);
    `CHK(pulses, 0)
    `CHK(cpi_code, 4'h7)
    wr(`SCR_ADDR_SOFT_RST, `SCR_SOFT_RST_VAL);
    `CHK(pulses, 1)
    `CHK(cpi_code, `SCR_CPI_CODE_RESET)
    `CHK(led_drive, 1'b0)
    exp_q.push_back(`SCR_LED_RESET);
    rd(`SCR_ADDR_LED_FORCE, 1);
    $display("test soft reset done");
    for (int k = 0; k < 100 && exp_q.size() > 0; k++) @(posedge clk_in);
    if (exp_q.size() > 0) begin
      num_errors++;
    end
    wrap_up();
  end
endmodule : scr_top_tb
